// ===== timer_pkg.sv
// package: constants and field layout for the eight/sixteen bit timer
package timer_pkg;
   localparam int unsigned DATA_W = 8;
   localparam int unsigned SRC_W = 3;
   localparam int unsigned SEL_W = 4;
   localparam int unsigned PRE_W = 15;
   // first control register fields
   localparam int unsigned CTL0_EN_BIT = 7;
   localparam int unsigned CTL0_OUT_BIT = 5;
   localparam int unsigned CTL0_WIDTH_BIT = 4;
   localparam int unsigned CTL0_POST_LSB = 0;
   // second control register fields
   localparam int unsigned CTL1_SRC_LSB = 5;
   localparam int unsigned CTL1_ASYNC_BIT = 4;
   localparam int unsigned CTL1_PRE_LSB = 0;
   localparam logic [7:0] CTL0_RESET = 8'h00;
   localparam logic [7:0] CTL1_RESET = 8'h00;
   localparam logic [7:0] COUNT_RESET = 8'h00;
   localparam logic [7:0] BYTE_MAX = 8'hff;
   // instruction clock is the system clock divided by four
   localparam logic [1:0] INSTR_DIV_LAST = 2'h3;
   localparam logic [PRE_W-1:0] PRE_ZERO = 15'h0000;
   localparam logic [SEL_W-1:0] POST_ZERO = 4'h0;
endpackage

// ===== timer_ctl_if.sv
// interface: clear and tick signals between timer core and prescaler
`timescale 1ns/1ps
`default_nettype none
interface timer_ctl_if;
   import timer_pkg::*;
   logic clear;
   logic [SEL_W-1:0] ratio;
   logic edge_in;
   logic tick;
   modport core (output clear, output ratio, output edge_in, input tick);
   modport pre (input clear, input ratio, input edge_in, output tick);
endinterface
`default_nettype wire

// ===== timer_prescaler.sv
// module: power of two input prescaler with clear
`timescale 1ns/1ps
`default_nettype none
module timer_prescaler
   import timer_pkg::*;
(
   input wire logic mclk, // system clock
   input wire logic sys_rst, // synchronous reset, active high
   timer_ctl_if.pre ctl // clear, ratio, edge in, tick out
);
   logic [PRE_W-1:0] cnt_q; // no software path to this count
   logic [PRE_W-1:0] cnt_d;
   logic [PRE_W-1:0] mask;
   logic tick_c;

   always_comb begin
      mask = PRE_W'((16'h0001 << ctl.ratio) - 16'h0001);
      cnt_d = cnt_q;
      tick_c = 1'b0;
      if (ctl.clear) begin
         cnt_d = PRE_ZERO;
      end else if (ctl.edge_in) begin
         if ((cnt_q & mask) == mask) begin
            cnt_d = PRE_ZERO;
            tick_c = 1'b1;
         end else begin
            cnt_d = cnt_q + PRE_W'(1);
         end
      end
   end

   assign ctl.tick = tick_c;

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         cnt_q <= PRE_ZERO;
      end else begin
         cnt_q <= cnt_d;
      end
   end

   pre_clear_a: assert property (@(posedge mclk) disable iff (sys_rst)
      ctl.clear |=> cnt_q == PRE_ZERO)
      else $error("prescaler count not cleared");
   pre_unity_a: assert property (@(posedge mclk) disable iff (sys_rst)
      (ctl.ratio == 4'h0 && ctl.edge_in && !ctl.clear) |-> ctl.tick)
      else $error("ratio one does not pass every edge");
   pre_hidden_a: assert property (@(posedge mclk) disable iff (sys_rst)
      (!ctl.edge_in && !ctl.clear) |=> $stable(cnt_q))
      else $error("prescaler moved without an edge");
endmodule
`default_nettype wire

// ===== timer_eight_sixteen_bit.sv
// module: timer core with 8-bit period and 16-bit free running modes
// Functional notes
// - one width-select bit picks eight-bit or sixteen-bit counting
// - counter advances one per rising edge of prescaled selected clock
// - eight-bit: low equals period buffer clears low, reloads buffer
// - sixteen-bit: low read latches upper byte into readable high register
// - sixteen-bit: high write fills buffer; low write moves it in
// - sixteen-bit: counter wraps from maximum to zero and keeps going
// - sixteen-bit: no automatic reload, counter runs free
// - source-select field in second control register picks clock source
// - async clear: clock synchronised to instruction clock, rate limited
// - synchronous mode halts during sleep
// - async set: count every selected input edge without synchronising
// - async mode keeps counting in sleep while source is active
// - sixteen prescale ratios chosen by four-bit field
// - prescaler count is hidden from software
// - prescaler clears on low write, control write and reset
// - postscaler one to sixteen, cleared like the prescaler
// - output toggles per postscaled match or rollover, readable as status
// - flag set on each output toggle; interrupt needs enable
// - timer operates only while module-enable bit is set
`timescale 1ns/1ps
`default_nettype none
module timer_eight_sixteen_bit
   import timer_pkg::*;
(
   input wire logic mclk, // system clock, 20 MHz
   input wire logic sys_rst, // synchronous reset, active high
   input wire logic sleep, // device asleep, system clock gated
   input wire logic [7:0] clock_sources, // candidate counter clocks
   input wire logic [7:0] wr_data, // software write data
   input wire logic count_low_wr, // write strobe, low counter register
   input wire logic count_high_wr, // write strobe, high register
   input wire logic control_first_wr, // write strobe, first control register
   input wire logic control_second_wr, // write strobe, second control register
   input wire logic count_low_rd, // read strobe, low counter register
   input wire logic timer_irq_flag_clr, // software clears the flag
   input wire logic timer_irq_enable, // interrupt enable
   output logic [7:0] count_low_reg, // low counter readback
   output logic [7:0] count_high_reg, // high register readback
   output logic [7:0] control_reg_first, // first control register readback
   output logic [7:0] control_reg_second, // second control register readback
   output logic timer_output, // postscaled toggling output
   output logic timer_irq_flag, // sticky interrupt flag
   output logic irq // interrupt request
);
   logic [7:0] ctl0_q, ctl0_d, ctl1_q, ctl1_d;
   logic [7:0] low_q, low_d, high_q, high_d, hbuf_q, hbuf_d;
   logic [1:0] idiv_q, idiv_d;
   logic src_q, src_d, sync_q, sync_d;
   logic [SEL_W-1:0] post_q, post_d;
   logic out_q, out_d, flag_q, flag_d;
   logic module_enable_bit, width_select, async_select;
   logic [SRC_W-1:0] clock_source_select;
   logic [SEL_W-1:0] prescale_select, postscale_select;
   logic src_raw, src_rise, instr_tick, adv, match, roll, event_c, toggle;
   logic clr;
   timer_ctl_if pre_if ();

   assign module_enable_bit = ctl0_q[CTL0_EN_BIT];
   assign width_select = ctl0_q[CTL0_WIDTH_BIT];
   assign postscale_select = ctl0_q[CTL0_POST_LSB +: SEL_W];
   assign clock_source_select = ctl1_q[CTL1_SRC_LSB +: SRC_W];
   assign async_select = ctl1_q[CTL1_ASYNC_BIT];
   assign prescale_select = ctl1_q[CTL1_PRE_LSB +: SEL_W];

   assign src_raw = clock_sources[clock_source_select];
   assign src_rise = src_raw && !src_q;
   // the system clock stops in sleep, so only the async path may move
   assign clr = count_low_wr || control_first_wr || control_second_wr;
   assign pre_if.clear = clr;
   assign pre_if.ratio = prescale_select;
   assign pre_if.edge_in = module_enable_bit && src_rise && (async_select || !sleep);
   assign instr_tick = idiv_q == INSTR_DIV_LAST;

   // sync mode: a tick waits for the next instruction-clock slot, capping rate
   always_comb begin
      idiv_d = sleep ? idiv_q : idiv_q + 2'h1;
      src_d = src_raw;
      sync_d = sync_q;
      adv = 1'b0;
      if (clr || !module_enable_bit) begin
         sync_d = 1'b0;
      end else if (async_select) begin
         adv = pre_if.tick;
         if (!sleep) begin
            sync_d = 1'b0;
         end
      end else if (!sleep) begin
         if (instr_tick) begin
            adv = sync_q || pre_if.tick;
            sync_d = 1'b0;
         end else if (pre_if.tick) begin
            sync_d = 1'b1;
         end
      end
      if (async_select && sleep) begin
         adv = pre_if.tick;
      end
      if (!async_select && sleep) begin
         adv = 1'b0;
      end
   end

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         idiv_q <= 2'h0;
         src_q <= 1'b0;
         sync_q <= 1'b0;
      end else begin
         idiv_q <= idiv_d;
         src_q <= src_d;
         sync_q <= sync_d;
      end
   end

   assign match = !width_select && adv && (low_q == hbuf_q);
   assign roll = width_select && adv && (low_q == BYTE_MAX) && (hbuf_q == BYTE_MAX);
   assign event_c = match || roll;
   assign toggle = event_c && (post_q == postscale_select);

   always_comb begin
      ctl0_d = ctl0_q;
      ctl1_d = ctl1_q;
      low_d = low_q;
      high_d = high_q;
      hbuf_d = hbuf_q;
      if (control_first_wr) begin
         ctl0_d = wr_data;
         ctl0_d[CTL0_OUT_BIT] = 1'b0;
         ctl0_d[6] = 1'b0;
      end
      if (control_second_wr) begin
         ctl1_d = wr_data;
      end
      // in sixteen-bit mode hbuf_q holds the live upper byte of the count
      if (adv) begin
         if (!width_select) begin
            if (match) begin
               low_d = COUNT_RESET;
               hbuf_d = high_q;
            end else begin
               low_d = low_q + 8'h01;
            end
         end else begin
            {hbuf_d, low_d} = {hbuf_q, low_q} + 16'h0001;
         end
      end
      if (count_low_rd && width_select) begin
         high_d = hbuf_q;
      end
      if (count_high_wr) begin
         high_d = wr_data;
      end
      if (count_low_wr) begin
         low_d = wr_data;
         if (width_select) begin
            hbuf_d = high_q;
         end
      end
   end

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         ctl0_q <= CTL0_RESET;
         ctl1_q <= CTL1_RESET;
         low_q <= COUNT_RESET;
         high_q <= COUNT_RESET;
         hbuf_q <= COUNT_RESET;
      end else begin
         ctl0_q <= ctl0_d;
         ctl1_q <= ctl1_d;
         low_q <= low_d;
         high_q <= high_d;
         hbuf_q <= hbuf_d;
      end
   end

   // output group: postscaler, toggling output and sticky flag
   always_comb begin
      post_d = post_q;
      out_d = out_q;
      flag_d = flag_q;
      if (clr) begin
         post_d = POST_ZERO;
      end else if (event_c) begin
         post_d = toggle ? POST_ZERO : post_q + 4'h1;
      end
      if (toggle) begin
         out_d = !out_q;
      end
      // a clear in the toggle cycle loses, so no event goes unseen
      if (timer_irq_flag_clr) begin
         flag_d = 1'b0;
      end
      if (toggle) begin
         flag_d = 1'b1;
      end
   end

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         post_q <= POST_ZERO;
         out_q <= 1'b0;
         flag_q <= 1'b0;
      end else begin
         post_q <= post_d;
         out_q <= out_d;
         flag_q <= flag_d;
      end
   end

   timer_prescaler u_pre (
      .mclk(mclk),
      .sys_rst(sys_rst),
      .ctl(pre_if.pre)
   );

   always_comb begin
      control_reg_first = ctl0_q;
      control_reg_first[CTL0_OUT_BIT] = out_q;
   end
   assign control_reg_second = ctl1_q;
   assign count_low_reg = low_q;
   assign count_high_reg = high_q;
   assign timer_output = out_q;
   assign timer_irq_flag = flag_q;
   assign irq = flag_q && timer_irq_enable;

   match_clear_a: assert property (@(posedge mclk) disable iff (sys_rst)
      (match && !count_low_wr) |=> low_q == 8'h00)
      else $error("period match did not clear low counter");
   wrap_zero_a: assert property (@(posedge mclk) disable iff (sys_rst)
      (roll && !count_low_wr) |=> (low_q == 8'h00 && hbuf_q == 8'h00))
      else $error("sixteen-bit counter did not wrap to zero");
   read_latch_a: assert property (@(posedge mclk) disable iff (sys_rst)
      (count_low_rd && width_select && !count_high_wr) |=> high_q == $past(hbuf_q))
      else $error("low read did not latch upper byte");
   high_write_a: assert property (@(posedge mclk) disable iff (sys_rst)
      (count_high_wr && width_select && !count_low_wr && !adv) |=> $stable(hbuf_q))
      else $error("high write reached live count directly");
   disabled_hold_a: assert property (@(posedge mclk) disable iff (sys_rst)
      (!module_enable_bit && !count_low_wr && !count_high_wr) |=> $stable(low_q))
      else $error("disabled timer advanced");
   sleep_halt_a: assert property (@(posedge mclk) disable iff (sys_rst)
      (sleep && !async_select) |-> !adv)
      else $error("synchronous timer moved in sleep");
   toggle_flag_a: assert property (@(posedge mclk) disable iff (sys_rst)
      toggle |=> (timer_irq_flag && timer_output != $past(timer_output)))
      else $error("toggle without flag");
   post_clear_a: assert property (@(posedge mclk) disable iff (sys_rst)
      clr |=> post_q == 4'h0)
      else $error("postscaler not cleared");
   // counting path and mode checks
   count_step_a: assert property (@(posedge mclk) disable iff (sys_rst)
      (adv && !width_select && !match && !count_low_wr) |=> low_q == $past(low_q) + 8'h01)
      else $error("eight-bit count did not step by one");
   wide_step_a: assert property (@(posedge mclk) disable iff (sys_rst)
      (adv && width_select && !count_low_wr) |=>
         {hbuf_q, low_q} == $past({hbuf_q, low_q}) + 16'h0001)
      else $error("sixteen-bit count did not step by one");
   free_run_a: assert property (@(posedge mclk) disable iff (sys_rst)
      (width_select && !adv && !count_low_wr) |=> $stable({hbuf_q, low_q}))
      else $error("sixteen-bit count moved without a step");
   period_buffer_a: assert property (@(posedge mclk) disable iff (sys_rst)
      (!width_select && !match) |=> $stable(hbuf_q))
      else $error("period buffer changed without a match");
   match_reload_a: assert property (@(posedge mclk) disable iff (sys_rst)
      match |=> hbuf_q == $past(high_q))
      else $error("period buffer not reloaded at match");
   low_write_a: assert property (@(posedge mclk) disable iff (sys_rst)
      count_low_wr |=> (low_q == $past(wr_data)
         && (!$past(width_select) || hbuf_q == $past(high_q))))
      else $error("low write did not load the count");
   source_edge_a: assert property (@(posedge mclk) disable iff (sys_rst)
      pre_if.edge_in |=> src_q)
      else $error("edge taken from an unselected source");
   sync_rate_a: assert property (@(posedge mclk) disable iff (sys_rst)
      (!async_select && adv) |-> instr_tick)
      else $error("synchronous step off the instruction slot");
   async_step_a: assert property (@(posedge mclk) disable iff (sys_rst)
      (async_select && pre_if.tick) |-> adv)
      else $error("asynchronous tick did not step the count");
   async_sleep_a: assert property (@(posedge mclk) disable iff (sys_rst)
      (async_select && sleep && pre_if.edge_in && prescale_select == 4'h0 && !clr) |-> adv)
      else $error("asynchronous count stopped in sleep");
   instr_freeze_a: assert property (@(posedge mclk) disable iff (sys_rst)
      sleep |=> $stable(idiv_q))
      else $error("instruction clock ran in sleep");
   enable_gate_a: assert property (@(posedge mclk) disable iff (sys_rst)
      !module_enable_bit |-> !adv)
      else $error("step while module disabled");
   out_status_a: assert property (@(posedge mclk) disable iff (sys_rst)
      toggle |=>
         control_reg_first[CTL0_OUT_BIT] != $past(control_reg_first[CTL0_OUT_BIT]))
      else $error("status bit did not follow the output");
   flag_sticky_a: assert property (@(posedge mclk) disable iff (sys_rst)
      (timer_irq_flag && !timer_irq_flag_clr) |=> timer_irq_flag)
      else $error("flag dropped without a clear");
   flag_clear_a: assert property (@(posedge mclk) disable iff (sys_rst)
      (timer_irq_flag_clr && !toggle) |=> !timer_irq_flag)
      else $error("flag clear had no effect");
   post_count_a: assert property (@(posedge mclk) disable iff (sys_rst)
      (event_c && !toggle && !clr) |=> post_q == $past(post_q) + 4'h1)
      else $error("postscaler did not count the event");
   post_bound_a: assert property (@(posedge mclk) disable iff (sys_rst)
      post_q <= postscale_select)
      else $error("postscaler ran past its ratio");
endmodule
`default_nettype wire

// ===== test_timer_eight_sixteen_bit.sv
// self-checking testbench for the eight/sixteen bit timer
`timescale 1ns/1ps
`default_nettype none
module test_timer_eight_sixteen_bit;
   import timer_pkg::*;
   logic mclk = 1'b0;
   logic sys_rst = 1'b1;
   logic sleep = 1'b0;
   logic [7:0] clock_sources = 8'h00;
   logic [7:0] wr_data = 8'h00;
   logic [3:0] wr_q = 4'h0;
   logic count_low_rd = 1'b0;
   logic timer_irq_flag_clr = 1'b0;
   logic timer_irq_enable = 1'b0;
   logic [7:0] count_low_reg, count_high_reg, control_reg_first, control_reg_second;
   logic timer_output, timer_irq_flag, irq;
   int n_fail = 0;
   int tests_run = 0;
   // reference state of the timer, advanced by the bench alongside the design
   logic [15:0] cnt = 16'h0000;
   logic [7:0] hreg = 8'h00, pbuf = 8'h00;
   logic [3:0] pn = 4'h0, psel = 4'h0, ps = 4'h0;
   logic [2:0] sel = 3'h0;
   logic en = 1'b0, wide = 1'b0, asy = 1'b0, out = 1'b0, flag = 1'b0;
   int pc = 0;
   int p;

   timer_eight_sixteen_bit DUT (.mclk(mclk), .sys_rst(sys_rst), .sleep(sleep),
      .clock_sources(clock_sources), .wr_data(wr_data), .count_low_wr(wr_q[0]),
      .count_high_wr(wr_q[1]), .control_first_wr(wr_q[2]), .control_second_wr(wr_q[3]),
      .count_low_rd(count_low_rd), .timer_irq_flag_clr(timer_irq_flag_clr),
      .timer_irq_enable(timer_irq_enable), .count_low_reg(count_low_reg),
      .count_high_reg(count_high_reg), .control_reg_first(control_reg_first),
      .control_reg_second(control_reg_second), .timer_output(timer_output),
      .timer_irq_flag(timer_irq_flag), .irq(irq));

   always #25 mclk = ~mclk;

   task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
      tests_run++;
      if (got !== exp) begin
         n_fail++;
         $display("wrong value at %0t ns: %s got %h expected %h", $time, what, got, exp);
      end
   endtask

   task automatic look();
      chk(count_low_reg, cnt[7:0], "low count");
      chk({7'h00, timer_output}, {7'h00, out}, "output");
      chk({7'h00, timer_irq_flag}, {7'h00, flag}, "flag");
      chk({7'h00, irq}, {7'h00, flag & timer_irq_enable}, "irq");
   endtask

   // kind: 0 low, 1 high, 2 first control, 3 second control
   task automatic wr(input int kind, input logic [7:0] d);
      @(negedge mclk);
      wr_data = d;
      wr_q[kind] = 1'b1;
      @(negedge mclk);
      wr_q = 4'h0;
      @(negedge mclk);
      if (kind != 1) begin
         pc = 0;
         ps = 4'h0;
      end
      if (kind == 0) begin
         cnt[7:0] = d;
         if (wide) cnt[15:8] = hreg;
      end
      if (kind == 1) begin
         hreg = d;
         chk(count_high_reg, d, "high register");
      end
      if (kind == 2) begin
         {en, wide, psel} = {d[7], d[4], d[3:0]};
         chk(control_reg_first, {d[7], 1'b0, out, d[4:0]}, "first control");
      end
      if (kind == 3) begin
         {sel, asy, pn} = d;
         chk(control_reg_second, d, "second control");
      end
   endtask

   task automatic advance();
      logic ev;
      ev = 1'b0;
      if (!wide) begin
         if (cnt[7:0] == pbuf) begin
            cnt[7:0] = 8'h00;
            pbuf = hreg;
            ev = 1'b1;
         end else cnt[7:0] = cnt[7:0] + 8'h01;
      end else begin
         cnt = cnt + 16'h0001;
         ev = (cnt == 16'h0000);
      end
      if (ev) begin
         if (ps == psel) begin
            ps = 4'h0;
            out = ~out;
            flag = 1'b1;
         end else ps = ps + 4'h1;
      end
   endtask

   // held three cycles each way so a synchronous step has its instruction slot
   task automatic pulse(input logic [7:0] mask);
      @(negedge mclk);
      clock_sources = mask;
      repeat (3) @(negedge mclk);
      clock_sources = 8'h00;
      repeat (3) @(negedge mclk);
      if (mask[sel] && en && (asy || !sleep)) begin
         pc++;
         if (pc == (1 << pn)) begin
            pc = 0;
            advance();
         end
      end
      look();
   endtask

   task automatic rd_low();
      @(negedge mclk);
      count_low_rd = 1'b1;
      @(negedge mclk);
      count_low_rd = 1'b0;
      @(negedge mclk);
      chk(count_high_reg, cnt[15:8], "latched high");
      if (wide) hreg = cnt[15:8];
   endtask

   task automatic give_verdict();
      $display("comparisons %0d mismatches %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   initial begin
      void'($urandom(75090));
      repeat (3) @(posedge mclk);
      @(negedge mclk);
      sys_rst = 1'b0;
      look();
      chk(control_reg_first, CTL0_RESET, "first control reset");
      chk(control_reg_second, CTL1_RESET, "second control reset");
      $display("test reset done");
      wr(3, 8'h10);
      repeat (3) pulse(8'h01);
      $display("test disabled done");
      wr(1, 8'($urandom_range(2, 6)));
      wr(2, 8'h80 | 8'($urandom_range(0, 2)));
      repeat (24) pulse(8'h01);
      timer_irq_enable = 1'b1;
      @(negedge mclk);
      look();
      @(negedge mclk);
      timer_irq_flag_clr = 1'b1;
      @(negedge mclk);
      timer_irq_flag_clr = 1'b0;
      flag = 1'b0;
      @(negedge mclk);
      look();
      $display("test period and flag done");
      for (int n = 0; n < 5; n++) begin
         wr(3, {3'h0, 1'b1, 4'(n)});
         repeat (2 << n) pulse(8'h01);
      end
      $display("test prescale done");
      for (int s = 0; s < 8; s++) begin
         wr(3, {3'(s), 1'b1, 4'h0});
         pulse(~(8'h01 << s));
         pulse(8'h01 << s);
      end
      $display("test source select done");
      wr(2, 8'h90);
      wr(3, 8'h10);
      wr(1, 8'hff);
      wr(0, 8'hfd);
      for (int i = 0; i < 5; i++) begin
         pulse(8'h01);
         rd_low();
      end
      wr(3, 8'h11);
      pulse(8'h01);
      wr(3, 8'h11);
      repeat (3) pulse(8'h01);
      $display("test sixteen bit done");
      wr(3, 8'h00);
      sleep = 1'b1;
      repeat (2) pulse(8'h01);
      sleep = 1'b0;
      repeat (2) pulse(8'h01);
      wr(3, 8'h10);
      sleep = 1'b1;
      p = $urandom_range(2, 4);
      repeat (p) pulse(8'h01);
      sleep = 1'b0;
      $display("test sleep done");
      give_verdict();
   end
endmodule
`default_nettype wire
